// >>> hw/jtp_pkg.sv
package jtp_pkg;

   localparam int LANES = 8;
   localparam int LANES_PER_LINK = 4;
   localparam int SYM_W = 10;
   localparam int PRBS_W = 23;

   typedef enum logic [3:0] {
      MODE_NORMAL = 4'h0,
      MODE_PRBS7 = 4'h1,
      MODE_PRBS15 = 4'h2,
      MODE_PRBS23 = 4'h3,
      MODE_RAMP = 4'h4,
      MODE_STP = 4'h5,
      MODE_D21_5 = 4'h6,
      MODE_K28_5 = 4'h7,
      MODE_REP_ILAS = 4'h8,
      MODE_RPAT = 4'h9
   } jtp_mode_t;

   // Taps as distances back in the transmitted bit stream
   localparam int PRBS7_A = 6;
   localparam int PRBS7_B = 7;
   localparam int PRBS15_A = 14;
   localparam int PRBS15_B = 15;
   localparam int PRBS23_A = 18;
   localparam int PRBS23_B = 23;
   localparam logic [PRBS_W-1:0] PRBS_SEED_BASE = 23'h000001;

   localparam logic [7:0] RAMP_FIRST = 8'h00;
   localparam logic [7:0] RAMP_STEP = 8'h01;
   localparam logic [7:0] STP_FRAME0_BASE = 8'h00;
   localparam logic [7:0] STP_FRAME1_BASE = 8'hFF;
   localparam logic [7:0] D21_5_OCTET = 8'hB5;
   localparam logic [7:0] K28_5_OCTET = 8'hBC;

   localparam logic [3:0] RPAT_FIRST = 4'h0;
   localparam logic [3:0] RPAT_LAST = 4'hB;
   localparam logic [95:0] RPAT_SEQ = {8'h59, 8'h35, 8'hFB, 8'h5E, 8'h14, 8'hB3,
                                       8'h8F, 8'h6B, 8'h47, 8'h23, 8'hD7, 8'hBE};

   // Link format modes that run only two lanes per link
   localparam logic [4:0] FMT_SC_4LANE = 5'h04;
   localparam logic [4:0] FMT_DC_4LANE = 5'h06;
   localparam logic [3:0] LINK_MASK_HALF = 4'h3;
   localparam logic [3:0] LINK_MASK_FULL = 4'hF;

   typedef struct packed {
      logic k_char;
      logic [7:0] octet;
   } jtp_norm_t;

   typedef struct packed {
      logic bypass;
      logic k_char;
      logic [SYM_W-1:0] sym;
   } jtp_lane_t;

endpackage

// >>> hw/jtp_prbs_lane.sv
`timescale 1ns/10ps
module jtp_prbs_lane #(
   parameter logic [jtp_pkg::PRBS_W-1:0] SEED = jtp_pkg::PRBS_SEED_BASE
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire jtp_pkg::jtp_mode_t mode,
   input wire logic restart,
   input wire logic step,
   output logic [jtp_pkg::SYM_W-1:0] sym
);
   import jtp_pkg::*;

   typedef struct packed {
      logic [PRBS_W-1:0] hist;
   } jtp_prbs_state_t;

   jtp_prbs_state_t st;
   jtp_prbs_state_t next_st;
   logic [PRBS_W-1:0] walk;
   logic nb;

   // hist[0] is the last bit sent, hist[k-1] the bit k places back
   function automatic logic tap_bit(input logic [PRBS_W-1:0] h, input jtp_mode_t m);
      case (m)
         MODE_PRBS7: tap_bit = h[PRBS7_A-1] ^ h[PRBS7_B-1];
         MODE_PRBS15: tap_bit = h[PRBS15_A-1] ^ h[PRBS15_B-1];
         default: tap_bit = h[PRBS23_A-1] ^ h[PRBS23_B-1];
      endcase
   endfunction

   // One step per serial bit, ten per character, first bit in the MSB
   always_comb
   begin
      walk = st.hist;
      sym = '0;
      nb = 1'b0;
      for (int i = SYM_W - 1; i >= 0; i--)
      begin
         nb = tap_bit(walk, mode);
         sym[i] = nb;
         walk = {walk[PRBS_W-2:0], nb};
      end
      next_st = st;
      if (restart)
         next_st.hist = SEED;
      else if (step)
         next_st.hist = walk;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         st <= '{hist: SEED};
      else
         st <= next_st;
   end

endmodule

// >>> hw/jtp_octet_pat.sv
`timescale 1ns/10ps
module jtp_octet_pat (
   input wire jtp_pkg::jtp_mode_t mode,
   input wire logic [1:0] lane_in_link,
   input wire logic data_phase,
   input wire logic [7:0] ramp_cnt,
   input wire logic frame,
   input wire logic [3:0] rpat_idx,
   input wire jtp_pkg::jtp_norm_t normal,
   output jtp_pkg::jtp_norm_t pat
);
   import jtp_pkg::*;

   logic [7:0] lane8;

   always_comb
   begin
      lane8 = {6'h00, lane_in_link};
      pat = normal;
      case (mode)
         MODE_RAMP:
         begin
            // Alignment characters from the link layer pass until data phase
            if (data_phase)
               pat = '{k_char: 1'b0, octet: ramp_cnt};
         end
         MODE_STP:
         begin
            // Only the short pattern exists; every format here carries 8-bit words
            pat.k_char = 1'b0;
            pat.octet = frame ? STP_FRAME1_BASE - lane8 : STP_FRAME0_BASE + lane8;
         end
         MODE_D21_5: pat = '{k_char: 1'b0, octet: D21_5_OCTET};
         MODE_K28_5: pat = '{k_char: 1'b1, octet: K28_5_OCTET};
         MODE_RPAT: pat = '{k_char: 1'b0, octet: RPAT_SEQ[{rpat_idx, 3'b000} +: 8]};
         default: pat = normal;
      endcase
   end

endmodule

// >>> hw/jtp_test_pattern_gen.sv
`timescale 1ns/10ps
// Function
// - The select field picks exactly one test pattern; unknown values mean normal.
// - Powered lanes depend only on the link format mode, never on the test mode.
// - PRBS bits go straight to the serializer, skipping the 8b/10b encoder.
// - PRBS7 bit is XOR of bits six and seven back, period 127.
// - PRBS15 taps 14 and 15, period 32767; PRBS23 taps 18 and 23.
// - Every lane starts its PRBS at a different phase; receivers self-synchronize.
// - Ramp mode sends the same wrapping 0x00..0xFF counter on all powered lanes after alignment.
// - Only the short transport pattern is ever produced, never the long one.
// - Transport test mode with 8-bit words produces the short transport pattern.
// - Short pattern repeats every two frames: 0x00..0x03, then 0xFF..0xFC per link.
// - Short pattern drives only enabled, lowest lanes; unused lanes carry nothing.
// - D21.5 mode sends D21.5 characters continuously on every active lane.
// - K28.5 mode sends K28.5 comma characters continuously on every active lane.
// - Repeated alignment mode never enters data phase, resending alignment forever.
// - A sync request in repeated alignment mode triggers code group synchronization.
// - RPAT mode repeats a 12-octet pattern through the 8b/10b encoder.
// - RPAT octets are BE D7 23 47 6B 8F B3 14 5E FB 35 59, then restart.
module jtp_test_pattern_gen (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [3:0] test_pattern_select,
   input wire logic [4:0] link_format_mode,
   input wire logic link_enable,
   input wire logic char_en,
   input wire logic link_data_phase,
   input wire logic sync_request,
   input wire jtp_pkg::jtp_norm_t [jtp_pkg::LANES-1:0] normal_lane,
   output jtp_pkg::jtp_lane_t [jtp_pkg::LANES-1:0] lane_out,
   output logic [jtp_pkg::LANES-1:0] lane_power,
   output logic transport_off,
   output logic ilas_repeat,
   output logic cgs_request,
   output logic order_error
);
   import jtp_pkg::*;

   typedef struct packed {
      jtp_mode_t mode;
      logic [7:0] ramp_cnt;
      logic frame;
      logic [3:0] rpat_idx;
      jtp_lane_t [LANES-1:0] lane;
      logic [LANES-1:0] power;
      logic transport_off;
      logic ilas_repeat;
      logic cgs_request;
      logic order_error;
   } jtp_state_t;

   jtp_state_t st;
   jtp_state_t next_st;
   jtp_mode_t sel_mode;
   logic mode_change;
   logic [SYM_W-1:0] prbs_sym [LANES];
   jtp_norm_t pat [LANES];

   function automatic jtp_mode_t decode_mode(input logic [3:0] sel);
      case (sel)
         MODE_PRBS7, MODE_PRBS15, MODE_PRBS23, MODE_RAMP, MODE_STP,
         MODE_D21_5, MODE_K28_5, MODE_REP_ILAS, MODE_RPAT: decode_mode = jtp_mode_t'(sel);
         default: decode_mode = MODE_NORMAL;
      endcase
   endfunction

   // Lanes 0..3 belong to link A, 4..7 to link B; the lowest lanes are the live ones
   function automatic logic [LANES-1:0] lanes_mask(input logic [4:0] fmt);
      logic [3:0] m;
      m = LINK_MASK_FULL;
      if (fmt == FMT_SC_4LANE || fmt == FMT_DC_4LANE)
         m = LINK_MASK_HALF;
      lanes_mask = {m, m};
   endfunction

   function automatic logic is_prbs(input jtp_mode_t m);
      is_prbs = (m == MODE_PRBS7) || (m == MODE_PRBS15) || (m == MODE_PRBS23);
   endfunction

   assign sel_mode = decode_mode(test_pattern_select);
   assign mode_change = (sel_mode != st.mode);

   for (genvar g = 0; g < LANES; g++)
   begin : g_lane
      // Distinct seeds give each lane its own phase of the sequence
      jtp_prbs_lane #(
         .SEED(PRBS_SEED_BASE + 23'(g))
      ) u_prbs (
         .core_clk(core_clk),
         .reset(reset),
         .mode(st.mode),
         .restart(mode_change),
         .step(char_en && is_prbs(st.mode)),
         .sym(prbs_sym[g])
      );

      jtp_octet_pat u_pat (
         .mode(st.mode),
         .lane_in_link(2'(g % LANES_PER_LINK)),
         .data_phase(link_data_phase),
         .ramp_cnt(st.ramp_cnt),
         .frame(st.frame),
         .rpat_idx(st.rpat_idx),
         .normal(normal_lane[g]),
         .pat(pat[g])
      );
   end

   always_comb
   begin
      next_st = st;
      next_st.mode = sel_mode;
      next_st.power = lanes_mask(link_format_mode);
      next_st.transport_off = (st.mode == MODE_RAMP);
      next_st.ilas_repeat = (st.mode == MODE_REP_ILAS);
      next_st.cgs_request = (st.mode == MODE_REP_ILAS) && sync_request;

      // Flag a test mode switched on under a live link; it is a controller fault
      if (st.mode == MODE_NORMAL && sel_mode != MODE_NORMAL && link_enable)
         next_st.order_error = 1'b1;
      else if (sel_mode == MODE_NORMAL)
         next_st.order_error = 1'b0;

      // Pattern phase restarts on every mode change so a checker sees a clean start
      if (mode_change)
      begin
         next_st.ramp_cnt = RAMP_FIRST;
         next_st.frame = 1'b0;
         next_st.rpat_idx = RPAT_FIRST;
      end
      else if (char_en)
      begin
         if (st.mode == MODE_RAMP && link_data_phase)
            next_st.ramp_cnt = st.ramp_cnt + RAMP_STEP;
         else if (st.mode == MODE_RAMP)
            next_st.ramp_cnt = RAMP_FIRST;
         if (st.mode == MODE_STP)
            next_st.frame = ~st.frame;
         if (st.mode == MODE_RPAT)
            next_st.rpat_idx = (st.rpat_idx == RPAT_LAST) ? RPAT_FIRST : st.rpat_idx + 4'h1;
      end

      // Lanes refresh once per character; between strobes they hold
      if (char_en)
      begin
         for (int l = 0; l < LANES; l++)
         begin
            if (!st.power[l])
               next_st.lane[l] = '0;
            else if (is_prbs(st.mode))
               next_st.lane[l] = '{bypass: 1'b1, k_char: 1'b0, sym: prbs_sym[l]};
            else
               next_st.lane[l] = '{bypass: 1'b0, k_char: pat[l].k_char, sym: {2'b00, pat[l].octet}};
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         st <= '0;
         st.mode <= MODE_NORMAL;
         st.power <= '0;
      end
      else
         st <= next_st;
   end

   assign lane_out = st.lane;
   assign lane_power = st.power;
   assign transport_off = st.transport_off;
   assign ilas_repeat = st.ilas_repeat;
   assign cgs_request = st.cgs_request;
   assign order_error = st.order_error;

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence s_settled(jtp_mode_t m);
      (test_pattern_select == m) ##1 (test_pattern_select == m && st.mode == m);
   endsequence

   sequence s_rpat_wrap;
      (st.mode == MODE_RPAT && !mode_change && char_en && st.rpat_idx == RPAT_LAST);
   endsequence

   sequence s_stp_char(logic f);
      (st.mode == MODE_STP && !mode_change && char_en && st.power[1] && st.frame == f);
   endsequence

   a_select_mode: assert property (
      (test_pattern_select == MODE_K28_5) |=> (st.mode == MODE_K28_5))
      else $error("select field not reflected in mode");

   a_power_format: assert property (
      1'b1 |=> (lane_power == lanes_mask($past(link_format_mode))))
      else $error("lane power not following format mode");

   a_prbs_bypass: assert property (
      (is_prbs(st.mode) && char_en && st.power[0]) |=> (lane_out[0].bypass && !lane_out[0].k_char))
      else $error("PRBS lane not bypassing encoder");

   a_ramp_count: assert property (
      (st.mode == MODE_RAMP && !mode_change && link_data_phase && char_en)
      |=> (st.ramp_cnt == $past(st.ramp_cnt) + RAMP_STEP))
      else $error("ramp counter did not advance by one");

   a_stp_frame0: assert property (
      s_stp_char(1'b0) |=> (lane_out[1].sym == 10'h001 && st.frame))
      else $error("short pattern frame 0 wrong");

   a_stp_frame1: assert property (
      s_stp_char(1'b1) |=> (lane_out[1].sym == 10'h0FE && !st.frame))
      else $error("short pattern frame 1 wrong");

   a_unused_quiet: assert property (
      (char_en && !st.power[2]) |=> (lane_out[2] == '0))
      else $error("unused lane carries data");

   a_d21_char: assert property (
      s_settled(MODE_D21_5) ##0 (char_en && st.power[0]) |=> (lane_out[0].sym == 10'h0B5 && !lane_out[0].k_char))
      else $error("D21.5 character missing");

   a_k28_char: assert property (
      s_settled(MODE_K28_5) ##0 (char_en && st.power[4]) |=> (lane_out[4].sym == 10'h0BC && lane_out[4].k_char))
      else $error("K28.5 character missing");

   a_rpat_wrap: assert property (
      s_rpat_wrap |=> (st.rpat_idx == RPAT_FIRST) ##0 (!st.power[0] || lane_out[0].sym == 10'h059))
      else $error("RPAT sequence did not wrap after last octet");

   a_ilas_hold: assert property (
      (st.mode == MODE_REP_ILAS) |=> ilas_repeat)
      else $error("repeated alignment not requested");

   a_cgs_request: assert property (
      (st.mode == MODE_REP_ILAS && sync_request) |=> cgs_request)
      else $error("sync request not turned into code group sync");

   a_normal_pass: assert property (
      (st.mode == MODE_NORMAL && !mode_change && char_en && st.power[0])
      |=> (lane_out[0].sym[7:0] == $past(normal_lane[0].octet) && !lane_out[0].bypass))
      else $error("normal path not passed through");

   a_order_flag: assert property (
      (st.mode == MODE_NORMAL && sel_mode != MODE_NORMAL && link_enable) |=> order_error)
      else $error("test mode under live link not flagged");

   // More checks: mode decode, ramp, RPAT and short pattern lanes, and no stale mode leaking a side signal into normal traffic
   sequence s_ramp_char(logic dp);
      (st.mode == MODE_RAMP && !mode_change && char_en && link_data_phase == dp);
   endsequence

   a_mode_unknown: assert property (
      (test_pattern_select > MODE_RPAT) |=> (st.mode == MODE_NORMAL))
      else $error("unknown select code not read as normal");

   a_mode_rpat: assert property (
      (test_pattern_select == MODE_RPAT) |=> (st.mode == MODE_RPAT))
      else $error("RPAT select not taken");

   a_mode_normal: assert property (
      (test_pattern_select == MODE_NORMAL) |=> (st.mode == MODE_NORMAL))
      else $error("normal select not taken");

   a_ramp_idle: assert property (
      s_ramp_char(1'b0) |=> (st.ramp_cnt == RAMP_FIRST))
      else $error("ramp counter moved before data phase");

   a_ramp_lane: assert property (
      s_ramp_char(1'b1) ##0 st.power[3]
      |=> (lane_out[3].sym == {2'b00, $past(st.ramp_cnt)} && !lane_out[3].k_char))
      else $error("ramp octet missing on lane");

   a_ramp_transport: assert property (
      (st.mode == MODE_RAMP) |=> transport_off)
      else $error("transport layer not disabled in ramp");

   a_transport_idle: assert property (
      (st.mode != MODE_RAMP) |=> !transport_off)
      else $error("transport disabled outside ramp");

   a_ilas_idle: assert property (
      (st.mode != MODE_REP_ILAS) |=> !ilas_repeat)
      else $error("alignment repeat outside its mode");

   a_cgs_idle: assert property (
      !(st.mode == MODE_REP_ILAS && sync_request) |=> !cgs_request)
      else $error("code group sync without request");

   a_rpat_step: assert property (
      (st.mode == MODE_RPAT && !mode_change && char_en && st.rpat_idx != RPAT_LAST)
      |=> (st.rpat_idx == $past(st.rpat_idx) + 4'h1))
      else $error("RPAT index did not step");

   a_rpat_first: assert property (
      (st.mode == MODE_RPAT && char_en && st.rpat_idx == RPAT_FIRST && st.power[0])
      |=> (lane_out[0].sym == 10'h0BE && !lane_out[0].bypass))
      else $error("RPAT first octet wrong");

   a_stp_link_b0: assert property (
      s_stp_char(1'b0) |=> (lane_out[4].sym == 10'h000))
      else $error("short pattern link B frame 0 wrong");

   a_stp_link_b1: assert property (
      s_stp_char(1'b1) |=> (lane_out[4].sym == 10'h0FF))
      else $error("short pattern link B frame 1 wrong");

   a_stp_lane3_f0: assert property (
      (st.mode == MODE_STP && char_en && st.power[3] && !st.frame) |=> (lane_out[3].sym == 10'h003))
      else $error("short pattern lane 3 frame 0 wrong");

   a_stp_lane3_f1: assert property (
      (st.mode == MODE_STP && char_en && st.power[3] && st.frame) |=> (lane_out[3].sym == 10'h0FC))
      else $error("short pattern lane 3 frame 1 wrong");

   a_stp_data_char: assert property (
      s_stp_char(1'b0) |=> (!lane_out[1].k_char && !lane_out[1].bypass))
      else $error("short pattern not sent as data octets");

   a_encoder_used: assert property (
      (!is_prbs(st.mode) && char_en && st.power[5]) |=> !lane_out[5].bypass)
      else $error("encoder bypassed outside PRBS");

   a_prbs_unused: assert property (
      (is_prbs(st.mode) && char_en && !st.power[7]) |=> (lane_out[7] == '0))
      else $error("unused lane carries PRBS");

   a_lane_hold: assert property (
      !char_en |=> $stable(lane_out))
      else $error("lane changed between characters");

   a_order_clear: assert property (
      (sel_mode == MODE_NORMAL) |=> !order_error)
      else $error("order flag not cleared");

   a_order_hold: assert property (
      (order_error && sel_mode != MODE_NORMAL) |=> order_error)
      else $error("order flag dropped early");

   a_order_quiet: assert property (
      (!order_error && !link_enable) |=> !order_error)
      else $error("order flag set with link disabled");

endmodule

// >>> test/jtp_rx_model.sv
`timescale 1ns/10ps
module jtp_rx_model (
   input wire logic core_clk,
   input wire logic reset,
   input wire jtp_pkg::jtp_lane_t [jtp_pkg::LANES-1:0] lane_out,
   input wire logic [jtp_pkg::LANES-1:0] lane_power,
   input wire logic char_en,
   input wire logic [4:0] tap_a,
   input wire logic [4:0] tap_b,
   input wire logic want_sync,
   output logic sync_request,
   output logic [15:0] bit_errors
);
   import jtp_pkg::*;
   logic [PRBS_W-1:0] hist [LANES];
   int seen [LANES];
   logic upd;
   logic nb;

   // Locks onto any phase; a bit is judged only once a full history is held
   always @(posedge core_clk)
   begin
      sync_request <= want_sync;
      upd <= char_en;
      if (reset || tap_a == 5'h00)
      begin
         bit_errors <= 16'h0000;
         for (int g = 0; g < LANES; g++)
            seen[g] = 0;
      end
      else if (upd)
      begin
         for (int g = 0; g < LANES; g++)
         begin
            if (lane_power[g] && !lane_out[g].bypass)
               bit_errors <= bit_errors + 16'h0001;
            for (int i = SYM_W - 1; i >= 0; i--)
            begin
               nb = lane_out[g].sym[i];
               if (lane_power[g] && seen[g] >= PRBS_W && nb !== (hist[g][tap_a - 1] ^ hist[g][tap_b - 1]))
                  bit_errors <= bit_errors + 16'h0001;
               hist[g] = {hist[g][PRBS_W-2:0], nb};
               seen[g]++;
            end
         end
      end
   end
endmodule

// >>> test/tb.sv
`timescale 1ns/10ps
module tb;
   import jtp_pkg::*;
   logic core_clk;
   logic reset;
   logic [3:0] sel;
   logic [4:0] fmt;
   logic link_enable;
   logic char_en;
   logic data_phase;
   logic sync_request;
   logic want_sync;
   logic [4:0] tap_a;
   logic [4:0] tap_b;
   logic [15:0] bit_errors;
   jtp_norm_t [LANES-1:0] normal_lane;
   jtp_lane_t [LANES-1:0] lane_out;
   logic [LANES-1:0] lane_power;
   logic transport_off;
   logic ilas_repeat;
   logic cgs_request;
   logic order_error;
   int n_errors;
   int comparisons;
   logic [7:0] rpat [12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F, 8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};

   jtp_test_pattern_gen u_dut (.core_clk(core_clk), .reset(reset), .test_pattern_select(sel),
      .link_format_mode(fmt), .link_enable(link_enable), .char_en(char_en), .link_data_phase(data_phase),
      .sync_request(sync_request), .normal_lane(normal_lane), .lane_out(lane_out), .lane_power(lane_power),
      .transport_off(transport_off), .ilas_repeat(ilas_repeat), .cgs_request(cgs_request),
      .order_error(order_error));
   jtp_rx_model u_rx (.core_clk(core_clk), .reset(reset), .lane_out(lane_out), .lane_power(lane_power),
      .char_en(char_en), .tap_a(tap_a), .tap_b(tap_b), .want_sync(want_sync), .sync_request(sync_request),
      .bit_errors(bit_errors));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Unpowered lanes are expected silent, so every lane check depends on the format
   function automatic logic [11:0] want(input int g, input logic k, input logic [7:0] oct);
      if ((fmt == 5'h04 || fmt == 5'h06) && g % 4 > 1)
         return 12'h000;
      return {1'b0, k, 2'b00, oct};
   endfunction

   task automatic cmp_lanes(input logic k, input logic [7:0] base, input logic [7:0] dir, input logic norm);
      for (int g = 0; g < LANES; g++)
         check(lane_out[g], norm ? want(g, normal_lane[g].k_char, normal_lane[g].octet)
            : want(g, k, 8'(base + dir * (g % 4))), "lane word");
   endtask

   // Passing through normal first so pattern state always restarts
   task automatic go(input logic [3:0] s);
      @(negedge core_clk);
      sel = 4'h0;
      repeat (2) @(negedge core_clk);
      sel = s;
      repeat (2) @(negedge core_clk);
   endtask

   task automatic pulse();
      @(negedge core_clk);
      char_en = 1'b1;
      @(negedge core_clk);
      char_en = 1'b0;
   endtask

   task automatic t_power();
      logic [4:0] fl [4] = '{5'h04, 5'h06, 5'h07, 5'h00};
      foreach (fl[i])
         for (int s = 0; s < 9; s += 7)
         begin
            fmt = fl[i];
            go(4'(s));
            check(lane_power, (fl[i] == 5'h04 || fl[i] == 5'h06) ? 8'h33 : 8'hFF, "lane power");
         end
   endtask

   task automatic t_fixed();
      fmt = 5'h04;
      go(4'h6);
      repeat (3)
      begin
         pulse();
         cmp_lanes(1'b0, D21_5_OCTET, 8'h00, 1'b0);
      end
      go(4'h7);
      repeat (3)
      begin
         pulse();
         cmp_lanes(1'b1, K28_5_OCTET, 8'h00, 1'b0);
      end
      go(4'hC);
      pulse();
      cmp_lanes(1'b0, 8'h00, 8'h00, 1'b1);
   endtask

   task automatic t_stp(input logic [4:0] f);
      fmt = f;
      go(4'h5);
      for (int i = 0; i < 4; i++)
      begin
         pulse();
         cmp_lanes(1'b0, i % 2 ? 8'hFF : 8'h00, i % 2 ? 8'hFF : 8'h01, 1'b0);
      end
   endtask

   task automatic t_rpat();
      fmt = 5'h07;
      go(4'h9);
      for (int i = 0; i < 13; i++)
      begin
         pulse();
         cmp_lanes(1'b0, rpat[i % 12], 8'h00, 1'b0);
      end
   endtask

   task automatic t_ramp();
      go(4'h4);
      check(transport_off, 1'b1, "transport off");
      pulse();
      cmp_lanes(1'b0, 8'h00, 8'h00, 1'b1);
      data_phase = 1'b1;
      for (int i = 0; i < 260; i++)
      begin
         pulse();
         cmp_lanes(1'b0, 8'(i), 8'h00, 1'b0);
      end
      data_phase = 1'b0;
   endtask

   task automatic t_prbs();
      logic [4:0] ta [3] = '{5'd6, 5'd14, 5'd18};
      logic [4:0] tb_ [3] = '{5'd7, 5'd15, 5'd23};
      logic [LANES-1:0] differ;
      for (int m = 0; m < 3; m++)
      begin
         tap_a = 5'h00;
         // PRBS15 runs on a half-lane format so silent lanes are exercised too
         fmt = (m == 1) ? 5'h06 : 5'h07;
         go(4'(m + 1));
         tap_a = ta[m];
         tap_b = tb_[m];
         differ = '0;
         char_en = 1'b1;
         repeat (301)
         begin
            @(negedge core_clk);
            for (int g = 1; g < LANES; g++)
               differ[g] = differ[g] | (lane_out[g].sym != lane_out[0].sym);
         end
         char_en = 1'b0;
         repeat (3) @(negedge core_clk);
         // One character can match while phases differ, so judge the whole run
         check(differ[LANES-1:1], 7'h7F, "lane phases equal");
         check(bit_errors, 16'h0000, "prbs bit errors");
      end
      tap_a = 5'h00;
   endtask

   task automatic t_ilas();
      go(4'h8);
      check(ilas_repeat, 1'b1, "alignment repeat");
      want_sync = 1'b1;
      repeat (2) @(negedge core_clk);
      check(cgs_request, 1'b1, "sync to cgs");
      want_sync = 1'b0;
      repeat (3) @(negedge core_clk);
      check(cgs_request, 1'b0, "cgs release");
   endtask

   task automatic t_order();
      go(4'h0);
      link_enable = 1'b1;
      sel = 4'h7;
      repeat (2) @(negedge core_clk);
      check(order_error, 1'b1, "order flag");
      sel = 4'h0;
      repeat (2) @(negedge core_clk);
      check(order_error, 1'b0, "order flag clear");
      link_enable = 1'b0;
      check(ilas_repeat | transport_off, 1'b0, "modes off");
      pulse();
      cmp_lanes(1'b0, 8'h00, 8'h00, 1'b1);
   endtask

   initial
   begin
      #200us;
      n_errors++;
      complete_run();
   end

   initial
   begin
      n_errors = 0;
      comparisons = 0;
      reset = 1'b1;
      sel = 4'h0;
      fmt = 5'h07;
      link_enable = 1'b0;
      char_en = 1'b0;
      data_phase = 1'b0;
      want_sync = 1'b0;
      tap_a = 5'h00;
      tap_b = 5'h00;
      for (int g = 0; g < LANES; g++)
         normal_lane[g] = {g[0], 8'(8'h40 + g)};
      repeat (20) @(negedge core_clk);
      check(lane_power, 8'h00, "reset power");
      check(|lane_out, 1'b0, "reset lanes");
      check({order_error, cgs_request, ilas_repeat, transport_off}, 4'h0, "reset flags");
      reset = 1'b0;
      t_power();
      t_fixed();
      t_stp(5'h04);
      t_stp(5'h07);
      t_rpat();
      t_ramp();
      t_prbs();
      t_ilas();
      t_order();
      complete_run();
   end
endmodule
